// File: include/fbie_pkg.sv
// Package of constants for the framer block interrupt enable logic
// What this block does
// - Enable bit 6 gates the whole loopback code block; each loopback source also needs its own enable.
// - Enable bit 5 passes or suppresses the loss of recovered clock interrupt directly at source level.
// - Enable bit 4 passes or suppresses the one second periodic interrupt directly at source level.
// - Enable bit 3 gates the data link controller block; each data link source also needs its own enable.
// - Enable bit 2 gates the slip buffer block and suppresses all its interrupts when clear.
// - Enable bit 1 gates the alarm and error block and suppresses all its interrupts when clear.
// - Enable bit 0 gates the framer block and suppresses all its interrupts when clear.
// - A source in a block-gated block reaches the pin only when block enable and source enable are both set.
// - A block's pending indication returns to zero when software reads the source status register that raised it, unless its synchronised request is still set.
package fbie_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [11:0] FBIE_GATE_OFS = 12'h000;
  localparam logic [11:0] FBIE_PEND_OFS = 12'h004;
  localparam logic [11:0] FBIE_SRC_EN_OFS = 12'h008;
  localparam logic [11:0] FBIE_SRC_ST_OFS = 12'h00C;
  localparam logic [11:0] FBIE_EVT_ST_OFS = 12'h010;
  localparam logic [11:0] FBIE_EVT_MASK_OFS = 12'h014;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int FBIE_BIT_FRAMER = 0;
  localparam int FBIE_BIT_ALARM = 1;
  localparam int FBIE_BIT_SLIP = 2;
  localparam int FBIE_BIT_DLINK = 3;
  localparam int FBIE_BIT_SECOND = 4;
  localparam int FBIE_BIT_CLKLOSS = 5;
  localparam int FBIE_BIT_LOOPBACK = 6;
  localparam int FBIE_NBLK = 7;
  localparam int FBIE_NSRC = 8;

  // Blocks that need a source-level enable on top of the block enable
  localparam logic [6:0] FBIE_BLOCK_GATED = 7'h4F;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [6:0] FBIE_GATE_RST = 7'h00;
  localparam logic [7:0] FBIE_SRC_EN_RST = 8'h00;
  localparam logic [1:0] FBIE_EVT_RST = 2'h0;
  localparam logic [31:0] FBIE_RDATA_RST = 32'h0000_0000;

  // Event bits in the event status register
  localparam int FBIE_EVT_RISE = 0;
  localparam int FBIE_EVT_FALL = 1;

endpackage

// File: rtl/fbie_sync.sv
// Two-flop synchroniser bank for the block and per-source request inputs
`timescale 1ns/1ps
module fbie_sync
  import fbie_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule

// File: rtl/fbie_top.sv
// Framer block interrupt enable logic with APB register slave
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module fbie_top
  import fbie_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block request inputs from the functional blocks (asynchronous)
  input wire logic [6:0] blk_req,
  // Source requests inside the block-gated blocks, one per block slot
  input wire logic [6:0] src_req,
  // Source status register read strobes (one pulse per block, same clock)
  input wire logic [6:0] src_stat_read,
  // Interrupt outputs
  output logic int_out,
  output logic [6:0] blk_pending,
  output logic event_irq
);

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  logic [7:0] req_raw;
  logic [7:0] req_sync;
  logic [6:0] src_sync;
  logic [6:0] src_sync_unused;

  assign req_raw = {1'b0, blk_req};

  fbie_sync #(.WIDTH(8)) u_sync_blk (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(req_raw),
    .sync_out(req_sync)
  );

  fbie_sync #(.WIDTH(7)) u_sync_src (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(src_req),
    .sync_out(src_sync)
  );

  assign src_sync_unused = src_sync;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [6:0] gate_q;
  logic [6:0] gate_d;
  logic [6:0] src_en_q;
  logic [6:0] src_en_d;
  logic [6:0] pend_q;
  logic [6:0] pend_d;
  logic [1:0] evt_st_q;
  logic [1:0] evt_st_d;
  logic [1:0] evt_mask_q;
  logic [1:0] evt_mask_d;
  logic int_q;
  logic int_d;
  logic evt_irq_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_acc = access & pwrite & pready_q;
  wire rd_acc = access & ~pwrite & pready_q;
  wire hit_gate = (paddr == FBIE_GATE_OFS);
  wire hit_pend = (paddr == FBIE_PEND_OFS);
  wire hit_src_en = (paddr == FBIE_SRC_EN_OFS);
  wire hit_src_st = (paddr == FBIE_SRC_ST_OFS);
  wire hit_evt_st = (paddr == FBIE_EVT_ST_OFS);
  wire hit_evt_mask = (paddr == FBIE_EVT_MASK_OFS);
  wire hit_any = hit_gate | hit_pend | hit_src_en | hit_src_st | hit_evt_st | hit_evt_mask;
  wire wr_lane0 = wr_acc & pstrb[0];

  // Bit 7 is reserved in T1 mode: never stored, reads zero
  assign gate_d = (wr_lane0 && hit_gate) ? pwdata[6:0] : gate_q;
  assign src_en_d = (wr_lane0 && hit_src_en) ? pwdata[6:0] : src_en_q;
  assign evt_mask_d = (wr_lane0 && hit_evt_mask) ? pwdata[1:0] : evt_mask_q;

  // ==========================================================================
  // Block pending indications
  // ==========================================================================
  // Pending is set by a synchronised block request and cleared by the read of the
  // source status register that raised it; a new request in that cycle wins.
  logic [6:0] pend_clr;
  logic [6:0] pend_set;
  assign pend_set = req_sync[6:0];
  assign pend_clr = src_stat_read;
  assign pend_d = pend_set | (pend_q & ~pend_clr);

  // ==========================================================================
  // Gating
  // ==========================================================================
  logic [6:0] src_ok;
  logic [6:0] gated;

  genvar g;
  generate
    for (g = 0; g < FBIE_NBLK; g++) begin : g_gate
      // Block-gated slots need a matching source enable; source-level slots do not
      assign src_ok[g] = FBIE_BLOCK_GATED[g] ? (src_en_q[g] & src_sync[g]) : 1'b1;
      assign gated[g] = pend_q[g] & gate_q[g] & src_ok[g];
    end
  endgenerate

  wire g_loop = gated[FBIE_BIT_LOOPBACK];
  wire g_clk = gated[FBIE_BIT_CLKLOSS];
  wire g_sec = gated[FBIE_BIT_SECOND];
  wire g_dl = gated[FBIE_BIT_DLINK];
  wire g_slip = gated[FBIE_BIT_SLIP];
  wire g_alarm = gated[FBIE_BIT_ALARM];
  wire g_frm = gated[FBIE_BIT_FRAMER];

  assign int_d = g_loop | g_clk | g_sec | g_dl | g_slip | g_alarm | g_frm;

  // ==========================================================================
  // Interrupt output events: rising and falling of the device interrupt
  // ==========================================================================
  wire ev_rise = int_d & ~int_q;
  wire ev_fall = ~int_d & int_q;
  wire [1:0] ev_set = {ev_fall, ev_rise};
  wire [1:0] ev_w1c = (wr_lane0 && hit_evt_st) ? pwdata[1:0] : 2'b00;
  assign evt_st_d = ev_set | (evt_st_q & ~ev_w1c);
  wire evt_irq_d = |(evt_st_d & evt_mask_d);

  // ==========================================================================
  // Read data and response
  // ==========================================================================
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = FBIE_RDATA_RST;
    if (hit_gate) begin
      rd_mux = {25'h0, gate_q};
    end else if (hit_pend) begin
      rd_mux = {25'h0, pend_q};
    end else if (hit_src_en) begin
      rd_mux = {25'h0, src_en_q};
    end else if (hit_src_st) begin
      rd_mux = {25'h0, src_sync};
    end else if (hit_evt_st) begin
      rd_mux = {30'h0, evt_st_q};
    end else if (hit_evt_mask) begin
      rd_mux = {30'h0, evt_mask_q};
    end
  end

  assign prdata_d = (setup && !pwrite) ? rd_mux : prdata_q;
  // Error stands only with ready, in the access cycle of an unmapped transfer
  assign pslverr_d = setup & ~hit_any;

  // Ready rises one cycle after setup, giving one wait-free access phase
  wire pready_d = setup;

  // ==========================================================================
  // Flip-flops
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= FBIE_GATE_RST;
      src_en_q <= FBIE_SRC_EN_RST[6:0];
      pend_q <= FBIE_GATE_RST;
      evt_st_q <= FBIE_EVT_RST;
      evt_mask_q <= FBIE_EVT_RST;
      int_q <= 1'b0;
      evt_irq_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
      src_en_q <= src_en_d;
      pend_q <= pend_d;
      evt_st_q <= evt_st_d;
      evt_mask_q <= evt_mask_d;
      int_q <= int_d;
      evt_irq_q <= evt_irq_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= FBIE_RDATA_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // rd_acc is only a naming aid for the read completion edge
  wire unused_ok = rd_acc | (|src_sync_unused) | req_sync[7];

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q & ~unused_ok | pslverr_q & unused_ok;
  assign int_out = int_q;
  assign blk_pending = pend_q;
  assign event_irq = evt_irq_q;

endmodule

// File: tb/fbie_monitor.sv
// Checker for the framer block interrupt enable logic
`timescale 1ns/1ps
module fbie_monitor
  import fbie_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt side
  input wire logic [6:0] blk_req,
  input wire logic [6:0] src_stat_read,
  input wire logic int_out,
  input wire logic [6:0] blk_pending
);
  // Shadow of the gate register, followed from bus writes
  logic [6:0] gate_m_q;
  wire gate_wr = psel && penable && pready && pwrite && pstrb[0] && paddr == FBIE_GATE_OFS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gate_m_q <= FBIE_GATE_RST;
    else if (gate_wr)
      gate_m_q <= pwdata[6:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence quiet_s; !blk_req[0] [*3] ##0 src_stat_read[0]; endsequence
  ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  gate_read_a: assert property (pready && !pwrite && !pslverr && paddr == FBIE_GATE_OFS |-> prdata == {25'h0, gate_m_q})
    else $error("gate readback wrong");
  clkloss_pass_a: assert property ($past(blk_pending[5] && gate_m_q[5]) |-> int_out)
    else $error("clock loss request not passed");
  second_pass_a: assert property ($past(blk_pending[4] && gate_m_q[4]) |-> int_out)
    else $error("second tick request not passed");
  int_cause_a: assert property (int_out |-> $past(|(blk_pending & gate_m_q)))
    else $error("interrupt without enabled pending request");
  pend_clear_a: assert property (quiet_s |=> !blk_pending[0])
    else $error("pending not cleared by status read");
  pend_rise_a: assert property ($rose(blk_pending[0]) |-> $past(blk_req[0], 3))
    else $error("pending set without request");
endmodule
bind fbie_top fbie_monitor u_fbie_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .blk_req, .src_stat_read, .int_out, .blk_pending);

// File: tb/fbie_tb_top.sv
// Self-checking testbench for the framer block interrupt enable logic
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module fbie_tb_top;
  import fbie_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_out, event_irq, erv, ia;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic [6:0] blk_req, src_req, src_stat_read, blk_pending;
  int n_errors = 0;
  int num_checks = 0;
  fbie_top u_fbie_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .blk_req(blk_req), .src_req(src_req), .src_stat_read(src_stat_read), .int_out(int_out),
    .blk_pending(blk_pending), .event_irq(event_irq));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask
  task automatic clr();
    blk_req <= 7'h00;
    src_req <= 7'h00;
    apb(1, FBIE_GATE_OFS, 0);
    tick(3);
    src_stat_read <= 7'h7F;
    tick(1);
    src_stat_read <= 7'h00;
    tick(2);
  endtask
  task automatic t_regs();
    apb(0, FBIE_GATE_OFS, 0);
    `CHK("gate reset", 32'h0, rdv)
    apb(1, FBIE_GATE_OFS, 32'hFF);
    apb(0, FBIE_GATE_OFS, 0);
    `CHK("gate bit7", 32'h7F, rdv)
    apb(0, 12'h0FC, 0);
    `CHK("unmapped", 1'b1, erv)
    apb(1, FBIE_GATE_OFS, 0);
  endtask
  task automatic t_direct(input int b);
    blk_req <= 7'h01 << b;
    tick(5);
    `CHK("direct off", 1'b0, int_out)
    apb(1, FBIE_GATE_OFS, 7'h01 << b);
    tick(2);
    `CHK("direct on", 1'b1, int_out)
    apb(1, FBIE_EVT_MASK_OFS, 0);
    tick(2);
    ia = event_irq;
    `CHK("event masked", 1'b0, ia)
    apb(1, FBIE_EVT_MASK_OFS, 3);
    tick(2);
    `CHK("event unmasked", 1'b1, event_irq)
    apb(1, FBIE_EVT_ST_OFS, 3);
    clr();
    apb(0, FBIE_EVT_ST_OFS, 0);
    `CHK("event fell", 2'h2, rdv[1:0])
    `CHK("event mask", 1'b1, ia ^ event_irq)
    apb(1, FBIE_EVT_ST_OFS, 3);
    tick(2);
    `CHK("event clear", 1'b0, event_irq)
  endtask
  task automatic t_gated(input int b);
    apb(1, FBIE_SRC_EN_OFS, 32'h7F);
    src_req <= 7'h01 << b;
    blk_req <= 7'h01 << b;
    tick(5);
    `CHK("block off", 1'b0, int_out)
    apb(1, FBIE_GATE_OFS, 7'h01 << b);
    tick(2);
    `CHK("block on", 1'b1, int_out)
    apb(1, FBIE_SRC_EN_OFS, 0);
    tick(2);
    `CHK("source off", 1'b0, int_out)
    src_req <= 7'h00;
    apb(1, FBIE_SRC_EN_OFS, 32'h7F);
    tick(4);
    `CHK("request off", 1'b0, int_out)
    clr();
  endtask
  task automatic t_pend();
    blk_req <= 7'h01;
    tick(1);
    blk_req <= 7'h00;
    tick(4);
    `CHK("pending set", 7'h01, blk_pending)
    src_stat_read <= 7'h01;
    tick(1);
    src_stat_read <= 7'h00;
    tick(1);
    `CHK("pending clear", 7'h00, blk_pending)
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #50us;
    n_errors++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {blk_req, src_req, src_stat_read} = '0;
    tick(12);
    presetn <= 1'b1;
    tick(1);
    t_regs();
    t_direct(5);
    t_direct(4);
    for (int i = 0; i < FBIE_NBLK; i++) begin
      if (FBIE_BLOCK_GATED[i])
        t_gated(i);
    end
    t_pend();
    complete_run();
  end
endmodule
